// ### hw/adc_conv_pkg.sv
// Contract
// - Restart strobe aborts and restarts conversion
// - Aborted conversion never loads output latch
// - Abort keeps done flag high
// - Conversion clock from host or RC
// - Input at negative level gives zero code
// - Straight binary, step is span over 256
// - Last step one and half below full
package adc_conv_pkg;
	// ==========================================
	// Converter widths and reset values
	localparam int CODE_BITS = 8;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] TRIAL_FIRST = 8'h80;
	localparam logic [7:0] TRIAL_LAST = 8'h01;
	localparam logic FLAG_IDLE = 1'h1;
	// ==========================================
	// Synchroniser lane positions and reset levels
	localparam int LANE_SEL = 0;
	localparam int LANE_WR = 1;
	localparam int LANE_RD = 2;
	localparam int LANE_CCLK = 3;
	localparam int LANE_COMP = 4;
	localparam int LANES = 5;
	localparam logic [4:0] LANES_RESET = 5'h07;
endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_r, s2_r, s3_r, level_r;
	logic [WIDTH-1:0] level_nxt;

	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync needs at least one lane");
	end

	// ==========================================
	// Accept a lane once stages two and three agree
	always_comb begin
		level_nxt = level_r;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_r[i] == s3_r[i]) level_nxt[i] = s3_r[i];
		end
	end

	// Three-stage shift and agreed level
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_r <= RESET_VALUE;
			s2_r <= RESET_VALUE;
			s3_r <= RESET_VALUE;
			level_r <= RESET_VALUE;
		end else begin
			s1_r <= pins_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_r <= level_nxt;
		end
	end

	assign level_out = level_r;
endmodule

// ### hw/adc_conversion_control.sv
`timescale 1ns/1ns
module adc_conversion_control (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic select_n_in,
	input wire logic write_n_in,
	input wire logic read_n_in,
	input wire logic conv_clock_in,
	input wire logic comparator_in,
	output logic [7:0] trial_code_out,
	output logic [7:0] data_out,
	output logic data_oe_n_out,
	output logic conversion_done_flag_n_out
);
	typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_CONV, ST_LOAD, ST_FLAG} seq_state_e;

	logic [adc_conv_pkg::LANES-1:0] pins_w, lvl_w;
	logic sel_n_w, wr_n_w, rd_n_w, cclk_w, comp_w;
	logic strobe_w, read_w, start_w, cclk_rise_w;
	seq_state_e state_r, state_nxt;
	logic [7:0] sar_r, sar_nxt, mask_r, mask_nxt, latch_r, latch_nxt;
	logic strobe_prev_r, cclk_prev_r, flag_r, flag_nxt, oe_n_r, oe_n_nxt;

	// ==========================================
	// Elaboration guard: the trial walk is eight bits
	if (adc_conv_pkg::CODE_BITS != 8) begin : g_code_bits
		$error("sequencer serves eight-bit codes only");
	end

	// Select paired with an active-low strobe
	function automatic logic both_low(input logic sel_n, input logic strobe_n);
		return !sel_n && !strobe_n;
	endfunction

	// ==========================================
	// Pin synchronisers
	// Every pin is asynchronous, so each lane is filtered
	assign pins_w = {comparator_in, conv_clock_in, read_n_in, write_n_in, select_n_in};

	pin_sync #(
		.WIDTH(adc_conv_pkg::LANES),
		.RESET_VALUE(adc_conv_pkg::LANES_RESET)
	) u_sync (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.pins_in(pins_w),
		.level_out(lvl_w)
	);

	// Lane unpacking
	assign sel_n_w = lvl_w[adc_conv_pkg::LANE_SEL];
	assign wr_n_w = lvl_w[adc_conv_pkg::LANE_WR];
	assign rd_n_w = lvl_w[adc_conv_pkg::LANE_RD];
	assign cclk_w = lvl_w[adc_conv_pkg::LANE_CCLK];
	assign comp_w = lvl_w[adc_conv_pkg::LANE_COMP];

	// ==========================================
	// Strobe and clock edge decoding
	assign strobe_w = both_low(sel_n_w, wr_n_w);
	assign read_w = both_low(sel_n_w, rd_n_w);
	assign start_w = strobe_prev_r && !strobe_w; // Strobe release
	assign cclk_rise_w = cclk_w && !cclk_prev_r;

	// ==========================================
	// Successive-approximation sequencer
	always_comb begin
		state_nxt = state_r;
		sar_nxt = sar_r;
		mask_nxt = mask_r;
		latch_nxt = latch_r;
		if (strobe_w) begin
			state_nxt = ST_IDLE;
			sar_nxt = '0;
			mask_nxt = '0;
		end else if (start_w) begin
			// fresh conversion start
			// Arm first: comparator still shows the old trial
			state_nxt = ST_ARM;
			sar_nxt = adc_conv_pkg::TRIAL_FIRST;
			mask_nxt = adc_conv_pkg::TRIAL_FIRST;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					// Waits for a start strobe
				end
				ST_ARM: begin
					if (cclk_rise_w) state_nxt = ST_CONV;
				end
				ST_CONV: begin
					if (cclk_rise_w) begin
						if (!comp_w) sar_nxt = sar_r & ~mask_r;
						if (mask_r == adc_conv_pkg::TRIAL_LAST) begin
							state_nxt = ST_LOAD;
						end else begin
							mask_nxt = mask_r >> 1;
							sar_nxt = (comp_w ? sar_r : (sar_r & ~mask_r)) | (mask_r >> 1);
						end
					end
				end
				ST_LOAD: begin
					latch_nxt = sar_r;
					state_nxt = ST_FLAG;
				end
				ST_FLAG: begin
					// Flag drops at the clock edge that leaves this state, then rest
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Done flag and bus drive
	always_comb begin
		flag_nxt = flag_r;
		if (state_r == ST_FLAG) begin
			flag_nxt = 1'h0;
		end else if (strobe_w || read_w) begin
			flag_nxt = adc_conv_pkg::FLAG_IDLE;
		end
		oe_n_nxt = !read_w;
	end

	// Sequencer registers
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= ST_IDLE;
			sar_r <= '0;
			mask_r <= '0;
			latch_r <= adc_conv_pkg::LATCH_RESET;
		end else begin
			state_r <= state_nxt;
			sar_r <= sar_nxt;
			mask_r <= mask_nxt;
			latch_r <= latch_nxt;
		end
	end

	// Edge history for strobe release and clock rise
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strobe_prev_r <= 1'h0;
			cclk_prev_r <= 1'h0;
		end else begin
			strobe_prev_r <= strobe_w;
			cclk_prev_r <= cclk_w;
		end
	end

	// Flag and output enable registers
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flag_r <= adc_conv_pkg::FLAG_IDLE;
			oe_n_r <= 1'h1;
		end else begin
			flag_r <= flag_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// Outputs straight from registers
	assign trial_code_out = sar_r;
	assign data_out = latch_r;
	assign data_oe_n_out = oe_n_r;
	assign conversion_done_flag_n_out = flag_r;

	// ==========================================
	// Assertions
	// All checks sit in the system clock domain
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);

	// Sequencer walk
	AST_RESTART_FRESH: assert property (start_w |=> state_r == ST_ARM && sar_r == 8'h80)
		else $error("restart did not begin fresh conversion");
	AST_STROBE_HOLDS: assert property (strobe_w |=> state_r == ST_IDLE && sar_r == 8'h00)
		else $error("sequencer not held during strobe");
	AST_ARM_SKIPS: assert property ((state_r == ST_ARM && cclk_rise_w && !strobe_w && !start_w)
		|=> state_r == ST_CONV && sar_r == $past(sar_r))
		else $error("settle edge changed the trial");
	AST_NO_PARTIAL_LOAD: assert property ((state_r != ST_LOAD || strobe_w) |=> $stable(latch_r))
		else $error("latch changed without completed conversion");
	AST_ABORT_FLAG_HIGH: assert property ((strobe_w && state_r != ST_FLAG) |=> flag_r)
		else $error("flag low during restart strobe");
	AST_BELOW_CLEARS: assert property ((state_r == ST_CONV && cclk_rise_w && !comp_w
		&& !strobe_w && !start_w) |=> (sar_r & $past(mask_r)) == 8'h00)
		else $error("bit kept with comparator low");
	AST_ABOVE_KEEPS: assert property ((state_r == ST_CONV && cclk_rise_w && comp_w
		&& !strobe_w && !start_w && mask_r != 8'h01)
		|=> (sar_r & $past(mask_r)) != 8'h00 && mask_r == ($past(mask_r) >> 1))
		else $error("binary walk wrong");
	AST_IDLE_TRIAL_STILL: assert property ((state_r == ST_IDLE && !strobe_w && !start_w) |=> $stable(sar_r))
		else $error("trial moved outside a conversion");
	AST_LAST_BIT: assert property ((state_r == ST_CONV && cclk_rise_w && mask_r == 8'h01
		&& !strobe_w && !start_w) |=> state_r == ST_LOAD)
		else $error("no load after last bit");
	// Bus and flag
	AST_BUS_DRIVE: assert property (read_w |=> !data_oe_n_out)
		else $error("bus not driven during read");
	AST_BUS_RELEASE: assert property (!read_w |=> data_oe_n_out)
		else $error("bus driven outside read");
	AST_LOAD_THEN_FLAG: assert property ((state_r == ST_LOAD && !strobe_w && !start_w)
		|=> latch_r == $past(sar_r) && flag_r ##1 !flag_r)
		else $error("latch or flag order wrong");
	AST_FLAG_SET_WINS: assert property (state_r == ST_FLAG |=> !flag_r)
		else $error("flag not lowered after load");
	AST_READ_CLEARS: assert property ((read_w && state_r != ST_FLAG) |=> flag_r)
		else $error("read did not clear flag");

	COV_COMPLETE: cover property (state_r == ST_LOAD ##2 !flag_r);
	COV_ABORT: cover property (state_r == ST_CONV && strobe_w);
	COV_READ: cover property (!flag_r ##1 read_w ##1 flag_r);
	COV_SETTLE: cover property (state_r == ST_ARM ##1 state_r == ST_CONV);
endmodule

// ### testbench/analog_front.sv
`timescale 1ns/1ns
// ==========================================
// Analog side: held input level and conversion clock
module analog_front (
	input wire logic [7:0] trial_in,
	input wire logic [7:0] level_in,
	output logic comp_out,
	output logic cclk_out
);
	initial begin
		cclk_out = 1'b0;
		forever #80 cclk_out = ~cclk_out;
	end
	assign comp_out = (level_in >= trial_in);
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic clock_in, arst_n_in, select_n_in, write_n_in, read_n_in, cclk, comp;
	logic [7:0] trial, data, level, latched;
	logic oe_n, flag_n;
	logic free_run, wr_pin;
	logic [7:0] exp_q[$];
	int errors, tests_run, i, n, seed;
	adc_conversion_control uut (.clock_in(clock_in), .arst_n_in(arst_n_in), .select_n_in(select_n_in),
		.write_n_in(wr_pin), .read_n_in(read_n_in), .conv_clock_in(cclk), .comparator_in(comp),
		.trial_code_out(trial), .data_out(data), .data_oe_n_out(oe_n), .conversion_done_flag_n_out(flag_n));
	analog_front afe (.trial_in(trial), .level_in(level), .comp_out(comp), .cclk_out(cclk));
	// free-run node joins strobe and flag
	assign wr_pin = free_run ? (flag_n & write_n_in) : write_n_in;
	// ==========================================
	// Clock and watchdog
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	initial begin
		#400000;
		errors++;
		wrap_up();
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clock_in);
		#1;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Start strobe: select and write low, then release
	task automatic strobe();
		select_n_in = 1'b0;
		write_n_in = 1'b0;
		tick(6);
		chk(trial, 8'h00);
		// Model: a start drops any pending result
		exp_q.delete();
		exp_q.push_back(level);
		write_n_in = 1'b1;
		select_n_in = 1'b1;
		tick(1);
	endtask
	task automatic wait_done();
		for (n = 0; n < 2000 && flag_n !== 1'b0; n++) tick(1);
		chk({7'h00, flag_n}, 8'h00);
		latched = exp_q.pop_front();
	endtask
	// Read cycle: bus driven only while select and read low
	task automatic rd_chk(input logic [7:0] exp);
		chk({7'h00, oe_n}, 8'h01);
		select_n_in = 1'b0;
		read_n_in = 1'b0;
		tick(6);
		chk({7'h00, oe_n}, 8'h00);
		chk(data, exp);
		chk({7'h00, flag_n}, 8'h01);
		read_n_in = 1'b1;
		select_n_in = 1'b1;
		tick(6);
		chk({7'h00, oe_n}, 8'h01);
	endtask
	task automatic wrap_up();
		$display("counts: tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		errors = 0;
		tests_run = 0;
		select_n_in = 1'b1;
		write_n_in = 1'b1;
		read_n_in = 1'b1;
		level = 8'h00;
		latched = 8'h00;
		free_run = 1'b0;
		arst_n_in = 1'b0;
		seed = $urandom(32'h3dbe);
		tick(10);
		arst_n_in = 1'b1;
		tick(4);
		chk({7'h00, flag_n}, 8'h01);
		// Full conversions at both ends and random levels
		for (i = 0; i < 8; i++) begin
			level = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'hfe : 8'($urandom);
			strobe();
			wait_done();
			rd_chk(latched);
			$display("test convert %0d done", i);
		end
		// Restart in mid-conversion
		level = 8'($urandom);
		strobe();
		tick(60);
		level = ~level;
		strobe();
		chk({7'h00, flag_n}, 8'h01);
		tick(5);
		chk(trial, 8'h80);
		rd_chk(latched);
		wait_done();
		rd_chk(latched);
		$display("test restart done");
		// Free-running loop after a second power-up
		free_run = 1'b1;
		select_n_in = 1'b0;
		level = 8'($urandom);
		arst_n_in = 1'b0;
		tick(10);
		arst_n_in = 1'b1;
		tick(20);
		chk({7'h00, flag_n}, 8'h01);
		chk(trial, 8'h00);
		// kick the joined node low once
		exp_q.push_back(level);
		write_n_in = 1'b0;
		tick(6);
		write_n_in = 1'b1;
		for (i = 0; i < 3; i++) begin
			wait_done();
			chk(data, latched);
			exp_q.push_back(level);
			for (n = 0; n < 50 && flag_n !== 1'b1; n++) tick(1);
			chk({7'h00, flag_n}, 8'h01);
		end
		free_run = 1'b0;
		select_n_in = 1'b1;
		$display("test free run done");
		wrap_up();
	end
endmodule
